// *** io_bank_pkg.sv ***
// Constants, layouts and types for the low I/O register bank
package io_bank_pkg;

  // ********************************************
  // Address map
  // ********************************************
  localparam int unsigned IO_REG_COUNT = 24;
  localparam logic [7:0] DATA_SPACE_OFFSET = 8'h20;
  localparam logic [7:0] BIT_ACCESS_LAST = 8'h1f;
  localparam logic [7:0] DATA_SPACE_LAST = 8'h3f;
  localparam logic [7:0] RESET_VALUE = 8'h00;

  localparam int unsigned OFS_POWER_REDUCTION_CTL = 'h00;
  localparam int unsigned OFS_DIGITAL_INPUT_DISABLE = 'h01;
  localparam int unsigned OFS_RESERVED_02 = 'h02;
  localparam int unsigned OFS_CONVERTER_CTL_B = 'h03;
  localparam int unsigned OFS_CONVERTER_RESULT_LOW = 'h04;
  localparam int unsigned OFS_CONVERTER_RESULT_HIGH = 'h05;
  localparam int unsigned OFS_CONVERTER_CTL_A = 'h06;
  localparam int unsigned OFS_CONVERTER_INPUT_SELECT = 'h07;
  localparam int unsigned OFS_COMPARATOR_CTL_STATUS = 'h08;
  localparam int unsigned OFS_RESERVED_09 = 'h09;
  localparam int unsigned OFS_RESERVED_0A = 'h0a;
  localparam int unsigned OFS_TIMER1_FLAGS = 'h0b;
  localparam int unsigned OFS_TIMER1_IRQ_MASK = 'h0c;
  localparam int unsigned OFS_SERIAL_UNIT_CTL = 'h0d;
  localparam int unsigned OFS_SERIAL_UNIT_STATUS = 'h0e;
  localparam int unsigned OFS_SERIAL_UNIT_SHIFT = 'h0f;
  localparam int unsigned OFS_SERIAL_UNIT_BUFFER = 'h10;
  localparam int unsigned OFS_RESERVED_11 = 'h11;
  localparam int unsigned OFS_PIN_CHANGE_MASK0 = 'h12;
  localparam int unsigned OFS_SCRATCH_REG0 = 'h13;
  localparam int unsigned OFS_SCRATCH_REG1 = 'h14;
  localparam int unsigned OFS_SCRATCH_REG2 = 'h15;
  localparam int unsigned OFS_PORT_B_INPUT = 'h16;
  localparam int unsigned OFS_PORT_B_DIRECTION = 'h17;

  // ********************************************
  // Field positions
  // ********************************************
  localparam int unsigned BIT_CONV_START = 6;
  localparam int unsigned BIT_CONV_DONE_FLAG = 4;
  localparam int unsigned BIT_CMP_OUTPUT = 5;
  localparam int unsigned BIT_CMP_FLAG = 4;
  localparam int unsigned BIT_SERIAL_COLLISION = 4;
  localparam int unsigned PORT_B_WIDTH = 4;

  // ********************************************
  // Per-register masks, highest index first, index 0 last
  // ********************************************
  typedef logic [IO_REG_COUNT-1:0][7:0] mask_array_type;

  // Bits that store the written value
  localparam mask_array_type WRITE_MASK = {
    8'h0f, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
    8'hff, 8'h0f, 8'hff, 8'h27, 8'h00, 8'h00, 8'h00, 8'hcf,
    8'hff, 8'hef, 8'h00, 8'h00, 8'hd7, 8'h00, 8'hff, 8'h0f};

  // Status flags cleared by writing one
  localparam mask_array_type CLEAR_ONE_MASK = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'he0, 8'h00, 8'h00, 8'h27, 8'h00, 8'h00, 8'h10,
    8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ********************************************
  // Core operations
  // ********************************************
  typedef enum logic [2:0] {
    load_op,
    store_op,
    set_io_bit_op,
    clear_io_bit_op,
    skip_if_io_bit_set_op,
    skip_if_io_bit_clear_op
  } core_op_type;

endpackage

// *** io_register_bit_access.sv ***
// Low I/O register bank with single-bit set, clear and test operations
// ********************************************
// Behaviour
// - Bit set/clear only for addresses 0x00-0x1F
// - Bit test reports skip on set/clear
// - Status flags clear on one, zero ignored
// - Bit operations touch only the addressed bit
// ********************************************
`timescale 1ns/1ps
`default_nettype none

module io_register_bit_access (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire io_bank_pkg::core_op_type acc_op,
  input wire logic [7:0] acc_addr,
  input wire logic [2:0] acc_bit,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] conv_result_low,
  input wire logic [7:0] conv_result_high,
  input wire logic conv_done,
  input wire logic cmp_output,
  input wire logic cmp_event,
  input wire logic [3:0] timer1_event,
  input wire logic [2:0] serial_event,
  input wire logic serial_collision,
  input wire logic [7:0] serial_buffer,
  input wire logic [io_bank_pkg::PORT_B_WIDTH-1:0] port_b_pins,
  output logic acc_ack,
  output logic [7:0] acc_rdata,
  output logic acc_skip,
  output logic [7:0] power_reduction_ctl,
  output logic [7:0] digital_input_disable,
  output logic [7:0] converter_ctl_b,
  output logic [7:0] converter_ctl_a,
  output logic [7:0] converter_input_select,
  output logic [7:0] comparator_ctl_status,
  output logic [7:0] timer1_flags,
  output logic [7:0] timer1_irq_mask,
  output logic [7:0] serial_unit_ctl,
  output logic [7:0] serial_unit_status,
  output logic [7:0] serial_unit_shift,
  output logic [7:0] pin_change_mask0,
  output logic [7:0] port_b_direction
);
  import io_bank_pkg::*;

  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    mask_array_type regs;
    logic ack;
    logic [7:0] rdata;
    logic skip;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic in_io;
  logic in_data;
  logic hit;
  logic is_bit_op;
  logic [4:0] io_index;
  logic [7:0] rel_addr;
  mask_array_type view;
  mask_array_type event_bits;
  logic [7:0] sel_view;
  logic [7:0] op_mask;
  logic [7:0] op_value;
  logic do_write;
  logic test_bit;

  // ********************************************
  // Address decode
  // ********************************************
  always_comb begin
    rel_addr = acc_addr - DATA_SPACE_OFFSET;
    in_io = (acc_addr <= BIT_ACCESS_LAST);
    in_data = (acc_addr > BIT_ACCESS_LAST) && (acc_addr <= DATA_SPACE_LAST);
    io_index = in_io ? acc_addr[4:0] : rel_addr[4:0];
    // Locations 0x18-0x1f belong to other banks, not decoded here; still acked, they read as 0x00
    hit = (in_io || in_data) && (io_index < 5'(IO_REG_COUNT));
    is_bit_op = (acc_op == set_io_bit_op) || (acc_op == clear_io_bit_op) ||
                (acc_op == skip_if_io_bit_set_op) || (acc_op == skip_if_io_bit_clear_op);
  end

  // ********************************************
  // Read view: stored bits plus live inputs
  // ********************************************
  always_comb begin
    for (int i = 0; i < IO_REG_COUNT; i++) begin
      view[i] = state_reg.regs[i] & (WRITE_MASK[i] | CLEAR_ONE_MASK[i]);
    end
    view[OFS_CONVERTER_RESULT_LOW] = conv_result_low;
    view[OFS_CONVERTER_RESULT_HIGH] = conv_result_high;
    view[OFS_COMPARATOR_CTL_STATUS][BIT_CMP_OUTPUT] = cmp_output;
    view[OFS_SERIAL_UNIT_STATUS][BIT_SERIAL_COLLISION] = serial_collision;
    view[OFS_SERIAL_UNIT_BUFFER] = serial_buffer;
    view[OFS_PORT_B_INPUT] = {4'h0, port_b_pins};
    sel_view = hit ? view[io_index] : 8'h00;
    test_bit = sel_view[acc_bit];
  end

  // ********************************************
  // Hardware flag events
  // ********************************************
  always_comb begin
    event_bits = '0;
    event_bits[OFS_CONVERTER_CTL_A][BIT_CONV_DONE_FLAG] = conv_done;
    event_bits[OFS_COMPARATOR_CTL_STATUS][BIT_CMP_FLAG] = cmp_event;
    event_bits[OFS_TIMER1_FLAGS] = {2'b00, timer1_event[3], 2'b00, timer1_event[2:0]};
    event_bits[OFS_SERIAL_UNIT_STATUS] = {serial_event, 5'h00};
  end

  // ********************************************
  // Write shaping
  // ********************************************
  always_comb begin
    op_mask = 8'h00;
    op_value = 8'h00;
    do_write = 1'b0;
    unique case (acc_op)
      store_op: begin
        op_mask = 8'hff;
        op_value = acc_wdata;
        do_write = 1'b1;
      end
      set_io_bit_op: begin
        op_mask = 8'h01 << acc_bit;
        op_value = 8'hff;
        do_write = in_io;
      end
      clear_io_bit_op: begin
        op_mask = 8'h01 << acc_bit;
        op_value = 8'h00;
        do_write = in_io;
      end
      default: begin
        op_mask = 8'h00;
        op_value = 8'h00;
        do_write = 1'b0;
      end
    endcase
    do_write = do_write && acc_valid && hit;
  end

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    logic [7:0] wr_bits;
    logic [7:0] clr_bits;
    wr_bits = 8'h00;
    clr_bits = 8'h00;
    state_next = state_reg;
    for (int i = 0; i < IO_REG_COUNT; i++) begin
      wr_bits = 8'h00;
      clr_bits = 8'h00;
      if (do_write && (io_index == 5'(i))) begin
        wr_bits = op_mask & WRITE_MASK[i] & ~CLEAR_ONE_MASK[i];
        clr_bits = op_mask & op_value & CLEAR_ONE_MASK[i];
      end
      state_next.regs[i] = (state_reg.regs[i] & ~wr_bits & ~clr_bits) | (op_value & wr_bits);
      // Event wins over a clear in the same cycle
      state_next.regs[i] = state_next.regs[i] | event_bits[i];
    end
    // Conversion start drops when the result lands
    if (conv_done) begin
      state_next.regs[OFS_CONVERTER_CTL_A][BIT_CONV_START] = 1'b0;
    end
    state_next.ack = acc_valid;
    state_next.rdata = 8'h00;
    state_next.skip = 1'b0;
    if (acc_valid && (acc_op == load_op)) begin
      state_next.rdata = sel_view;
    end
    if (acc_valid && in_io && hit && is_bit_op) begin
      if (acc_op == skip_if_io_bit_set_op) begin
        state_next.skip = test_bit;
      end else if (acc_op == skip_if_io_bit_clear_op) begin
        state_next.skip = ~test_bit;
      end
    end
  end

  // ********************************************
  // Registers
  // ********************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.regs <= {IO_REG_COUNT{RESET_VALUE}};
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 8'h00;
      state_reg.skip <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************************
  // Outputs, straight from flops
  // ********************************************
  assign acc_ack = state_reg.ack;
  assign acc_rdata = state_reg.rdata;
  assign acc_skip = state_reg.skip;
  assign power_reduction_ctl = state_reg.regs[OFS_POWER_REDUCTION_CTL];
  assign digital_input_disable = state_reg.regs[OFS_DIGITAL_INPUT_DISABLE];
  assign converter_ctl_b = state_reg.regs[OFS_CONVERTER_CTL_B];
  assign converter_ctl_a = state_reg.regs[OFS_CONVERTER_CTL_A];
  assign converter_input_select = state_reg.regs[OFS_CONVERTER_INPUT_SELECT];
  assign comparator_ctl_status = state_reg.regs[OFS_COMPARATOR_CTL_STATUS];
  assign timer1_flags = state_reg.regs[OFS_TIMER1_FLAGS];
  assign timer1_irq_mask = state_reg.regs[OFS_TIMER1_IRQ_MASK];
  assign serial_unit_ctl = state_reg.regs[OFS_SERIAL_UNIT_CTL];
  assign serial_unit_status = state_reg.regs[OFS_SERIAL_UNIT_STATUS];
  assign serial_unit_shift = state_reg.regs[OFS_SERIAL_UNIT_SHIFT];
  assign pin_change_mask0 = state_reg.regs[OFS_PIN_CHANGE_MASK0];
  assign port_b_direction = state_reg.regs[OFS_PORT_B_DIRECTION];

endmodule

`default_nettype wire

// *** core_model.sv ***
// Processor core model issuing requests to the I/O bank
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk_sys,
  output logic acc_valid,
  output io_bank_pkg::core_op_type acc_op,
  output logic [7:0] acc_addr,
  output logic [2:0] acc_bit,
  output logic [7:0] acc_wdata
);
  import io_bank_pkg::*;
  logic [8:0] exp_q[$];
  initial begin
    acc_valid = 1'b0;
    acc_op = load_op;
    acc_addr = 8'h00;
    acc_bit = 3'h0;
    acc_wdata = 8'h00;
  end
  task automatic issue(input core_op_type o, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] d, input logic [8:0] e);
    if (o == store_op && (a & 8'hdf) inside {8'h02, 8'h09, 8'h0a, 8'h11}) return;
    @(posedge clk_sys);
    #1 acc_valid = 1'b1;
    acc_op = o;
    acc_addr = a;
    acc_bit = b;
    acc_wdata = ((a & 8'hdf) == 8'h0c) ? (d & 8'h27) : d;
    exp_q.push_back(e);
  endtask
  // Released address and write data flip so a stale value never looks valid
  task automatic idle();
    @(posedge clk_sys);
    #1 acc_valid = 1'b0;
    acc_addr = ~acc_addr;
    acc_wdata = ~acc_wdata;
  endtask
endmodule
`default_nettype wire

// *** io_bank_monitor.sv ***
// Concurrent checks on the I/O bank ports
`timescale 1ns/1ps
`default_nettype none
module io_bank_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire io_bank_pkg::core_op_type acc_op,
  input wire logic [7:0] acc_addr,
  input wire logic [2:0] acc_bit,
  input wire logic [7:0] acc_wdata,
  input wire logic [3:0] timer1_event,
  input wire logic acc_ack,
  input wire logic acc_skip,
  input wire logic [7:0] timer1_irq_mask,
  input wire logic [7:0] timer1_flags
);
  import io_bank_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic bit_op, test_op, hit, quiet;
  logic [7:0] oh, bit_val;
  assign bit_op = acc_valid && (acc_op == set_io_bit_op || acc_op == clear_io_bit_op);
  assign test_op = acc_valid && (acc_op == skip_if_io_bit_set_op ||
                                 acc_op == skip_if_io_bit_clear_op);
  assign hit = timer1_irq_mask[acc_bit] ^ (acc_op == skip_if_io_bit_clear_op);
  assign oh = 8'h01 << acc_bit;
  assign bit_val = (acc_op == set_io_bit_op) ? ((timer1_irq_mask | oh) & 8'h27)
                                             : (timer1_irq_mask & ~oh);
  assign quiet = timer1_event == 4'h0;
  chk_ack_follows_req: assert property (acc_valid |=> acc_ack)
    else $error("ack missing after request");
  chk_no_spare_ack: assert property (!acc_valid |=> !acc_ack)
    else $error("ack without request");
  chk_high_bitop_void: assert property (bit_op && acc_addr > 8'h1f && quiet
    |=> $stable(timer1_flags) && $stable(timer1_irq_mask)) else $error("high bit op acted");
  chk_high_test_void: assert property (test_op && acc_addr > 8'h1f |=> !acc_skip)
    else $error("high bit test skipped");
  chk_skip_only_test: assert property (acc_valid && !test_op |=> !acc_skip)
    else $error("skip outside bit test");
  chk_test_mask_bit: assert property (test_op && acc_addr == 8'h0c
    |=> acc_skip == $past(hit)) else $error("wrong skip on mask bit");
  chk_bitop_one_bit: assert property (bit_op && acc_addr == 8'h0c
    |=> timer1_irq_mask == $past(bit_val)) else $error("bit op touched other bits");
  chk_flag_store: assert property (acc_valid && acc_op == store_op && acc_addr == 8'h0b
    && quiet |=> timer1_flags == ($past(timer1_flags) & ~$past(acc_wdata)))
    else $error("flag store wrong");
  chk_flag_bit_clear: assert property (bit_op && acc_op == set_io_bit_op
    && acc_addr == 8'h0b && quiet |=> timer1_flags == ($past(timer1_flags) & ~$past(oh)))
    else $error("flag bit op wrong");
  chk_alias_store: assert property (acc_valid && acc_op == store_op && acc_addr == 8'h2c
    |=> timer1_irq_mask == ($past(acc_wdata) & 8'h27)) else $error("alias store wrong");
endmodule
bind io_register_bit_access io_bank_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
  .acc_valid(acc_valid), .acc_op(acc_op), .acc_addr(acc_addr), .acc_bit(acc_bit),
  .acc_wdata(acc_wdata), .timer1_event(timer1_event), .acc_ack(acc_ack),
  .acc_skip(acc_skip), .timer1_irq_mask(timer1_irq_mask), .timer1_flags(timer1_flags));
`default_nettype wire

// *** io_register_bit_access_tb.sv ***
// Self-checking bench for the low I/O register bank
`timescale 1ns/1ps
`default_nettype none
module io_register_bit_access_tb;
  import io_bank_pkg::*;
  logic clk_sys, rst_n, acc_valid, acc_ack, acc_skip;
  core_op_type acc_op;
  logic [7:0] acc_addr, acc_wdata, acc_rdata, lo, hi, sbuf, mask, a, flags, irqm;
  logic [7:0] m[3];
  logic [2:0] acc_bit;
  logic [3:0] pins, t1ev;
  logic [8:0] e;
  logic [31:0] seed = 32'h3df27a02, r;
  int n_errors = 0, n_tests = 0, k, j;
  core_model core (.clk_sys(clk_sys), .acc_valid(acc_valid), .acc_op(acc_op),
    .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata));
  io_register_bit_access dut (.clk_sys(clk_sys), .rst_n(rst_n), .acc_valid(acc_valid),
    .acc_op(acc_op), .acc_addr(acc_addr), .acc_bit(acc_bit), .acc_wdata(acc_wdata),
    .conv_result_low(lo), .conv_result_high(hi), .conv_done(1'b0), .cmp_output(1'b0),
    .cmp_event(1'b0), .timer1_event(t1ev), .serial_event(3'h0), .serial_collision(1'b0),
    .serial_buffer(sbuf), .port_b_pins(pins), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
    .acc_skip(acc_skip), .power_reduction_ctl(), .digital_input_disable(),
    .converter_ctl_b(), .converter_ctl_a(), .converter_input_select(),
    .comparator_ctl_status(), .timer1_flags(flags), .timer1_irq_mask(irqm),
    .serial_unit_ctl(), .serial_unit_status(), .serial_unit_shift(),
    .pin_change_mask0(), .port_b_direction());
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string s, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Oldest note pairs with each answer
  always @(posedge clk_sys) begin
    if (acc_ack === 1'b1) begin
      e = (core.exp_q.size() > 0) ? core.exp_q.pop_front() : 9'bx;
      chk("answer", {acc_skip, acc_rdata}, e);
    end
  end
  initial begin
    #20000 n_errors++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    t1ev = 4'h0;
    m = '{default: 8'h00};
    r = rnd();
    {pins, sbuf, hi, lo} = r[27:0];
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    for (k = 0; k < 24; k++) begin
      r = rnd();
      j = k % 3;
      a = 8'h13 + 8'(j) + {2'b00, r[8], 5'h00};
      m[j] = r[7:0];
      core.issue(store_op, a, 3'h0, r[7:0], 9'h000);
      core.issue(load_op, a ^ 8'h20, 3'h0, 8'h00, {1'b0, m[j]});
      m[j][r[11:9]] = 1'b1;
      core.issue(set_io_bit_op, a & 8'h1f, r[11:9], 8'h00, 9'h000);
      core.issue(skip_if_io_bit_set_op, a & 8'h1f, r[14:12], 8'h00, {m[j][r[14:12]], 8'h00});
      m[j][r[17:15]] = 1'b0;
      core.issue(clear_io_bit_op, a & 8'h1f, r[17:15], 8'h00, 9'h000);
      core.issue(skip_if_io_bit_clear_op, a & 8'h1f, r[14:12], 8'h00, {~m[j][r[14:12]], 8'h00});
      core.issue(set_io_bit_op, a | 8'h20, r[20:18], 8'h00, 9'h000);
      core.issue(skip_if_io_bit_clear_op, a | 8'h20, r[20:18], 8'h00, 9'h000);
      core.issue(load_op, a, 3'h0, 8'h00, {1'b0, m[j]});
    end
    core.issue(load_op, 8'h04, 3'h0, 8'h00, {1'b0, lo});
    core.issue(load_op, 8'h25, 3'h0, 8'h00, {1'b0, hi});
    core.issue(load_op, 8'h10, 3'h0, 8'h00, {1'b0, sbuf});
    core.issue(load_op, 8'h02, 3'h0, 8'h00, 9'h000);
    core.issue(store_op, 8'h16, 3'h0, 8'hff, 9'h000);
    core.issue(load_op, 8'h36, 3'h0, 8'h00, {5'h00, pins});
    core.issue(skip_if_io_bit_set_op, 8'h16, 3'h0, 8'h00, {pins[0], 8'h00});
    r = rnd();
    mask = ((r[7:0] & 8'h27) | 8'h02) & 8'hfe;
    core.issue(store_op, 8'h2c, 3'h0, r[7:0], 9'h000);
    core.issue(set_io_bit_op, 8'h0c, 3'h1, 8'h00, 9'h000);
    core.issue(clear_io_bit_op, 8'h0c, 3'h0, 8'h00, 9'h000);
    core.issue(skip_if_io_bit_set_op, 8'h0c, 3'h1, 8'h00, 9'h100);
    core.idle();
    chk("irq mask", {1'b0, irqm}, {1'b0, mask});
    @(posedge clk_sys);
    #1 t1ev = 4'hf;
    @(posedge clk_sys);
    #1 t1ev = 4'h0;
    chk("flags raised", {1'b0, flags}, 9'h027);
    core.issue(store_op, 8'h0b, 3'h0, 8'h00, 9'h000);
    core.issue(set_io_bit_op, 8'h0b, 3'h0, 8'h00, 9'h000);
    core.issue(clear_io_bit_op, 8'h0b, 3'h1, 8'h00, 9'h000);
    core.issue(skip_if_io_bit_set_op, 8'h0b, 3'h2, 8'h00, 9'h100);
    core.issue(load_op, 8'h2b, 3'h0, 8'h00, 9'h026);
    core.issue(store_op, 8'h0b, 3'h0, 8'h20, 9'h000);
    core.idle();
    chk("flags cleared", {1'b0, flags}, 9'h006);
    repeat (3) @(posedge clk_sys);
    test_done();
  end
endmodule
`default_nettype wire
